// ==== include/bwta_regs.vh ====
// Constants for the byte/word transfer and 8-bit arithmetic datapath.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef BWTA_REGS_VH
`define BWTA_REGS_VH
// Operation codes
`define BWTA_OP_XCHB 4'h0
`define BWTA_OP_MOVE_WORD_TO_AX 4'h1
`define BWTA_OP_MOVE_WORD_FROM_AX 4'h2
`define BWTA_OP_EXCHANGE_WORD 4'h3
`define BWTA_OP_ADD 4'h4
`define BWTA_OP_ADD_WITH_CARRY 4'h5
`define BWTA_OP_SUB 4'h6
`define BWTA_OP_SUBTRACT_WITH_BORROW 4'h7
// Operand sources
`define BWTA_SRC_REG 2'h0
`define BWTA_SRC_IMM 2'h1
`define BWTA_SRC_MEM 2'h2
// Destinations for arithmetic
`define BWTA_DST_A 2'h0
`define BWTA_DST_REG 2'h1
`define BWTA_DST_MEM 2'h2
// Register indices
`define BWTA_R_X 3'h0
`define BWTA_R_A 3'h1
`define BWTA_R_C 3'h2
`define BWTA_R_B 3'h3
`define BWTA_R_E 3'h4
`define BWTA_R_D 3'h5
`define BWTA_R_L 3'h6
`define BWTA_R_H 3'h7
// Register pair indices
`define BWTA_RP_AX 2'h0
// Reset values
`define BWTA_REG_RESET 8'h00
`define BWTA_FLAG_RESET 1'b0
// Flag bit positions on the flag output
`define BWTA_FLAG_CARRY 0
`define BWTA_FLAG_HALF_CARRY 1
`define BWTA_FLAG_Z 2
// Clock counts
`define BWTA_CLK_XCH_REG 8'h02
`define BWTA_CLK_WORD_REG 8'h04
`define BWTA_CLK_ARITH_REG 8'h04
`define BWTA_CLK_IMM_REG 8'h04
`define BWTA_CLK_MEM_WAIT_IDLE 8'h00
`endif

// ==== hw/bwta_alu8.v ====
// 8-bit add/subtract unit with carry and half-carry out.
// Assumes purely combinational use inside the datapath.
`timescale 1ns/1ps
module bwta_alu8 (
	a,
	b,
	cin,
	sub,
	res,
	cout,
	hout,
	zout
);
	input wire [7:0] a;
	input wire [7:0] b;
	input wire cin;
	input wire sub;
	output reg [7:0] res;
	output reg cout;
	output reg hout;
	output wire zout;

	reg [4:0] lo;
	reg [4:0] hi;

	always @* begin
		if (sub) begin
			lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
			hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
		end else begin
			lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
			hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		end
		res = {hi[3:0], lo[3:0]};
		cout = hi[4];
		hout = lo[4];
	end

	assign zout = (res == 8'h00);
endmodule

// ==== hw/bwta_core.v ====
// Execution datapath for byte exchange, word move/exchange and 8-bit add/subtract.
// Assumes a sequencer issues one operation at a time and a memory side that
// answers reads and writes with a ready strobe, stretched by wait states.
`timescale 1ns/1ps
`include "bwta_regs.vh"

// Functional notes
// RULE1 - Fast RAM or no data access uses short count; other areas use long count.
// RULE2 - One instruction clock equals one period of the selected core clock.
// RULE3 - Counts hold for fetch from internal ROM; other fetches may be slower.
// RULE4 - Each external byte read adds the read wait states once.
// RULE5 - Each external byte write adds write wait states; word store adds twice.
// RULE6 - Byte exchange swaps accumulator and register or memory; flags untouched.
// RULE7 - Add stores 8-bit sum, updates zero, half-carry and carry flags.
// RULE8 - Add with carry adds operand plus carry, updates all three flags.
// RULE9 - Subtract stores difference, carry is borrow, zero and half-carry updated.
// RULE10 - Subtract with borrow removes operand and carry, updates all three flags.
// RULE11 - Word moves and exchange accept only BC, DE, HL pairs; no flags change.
// RULE12 - Half-carry from bit 3 carry or borrow; zero when result is zero.
// RULE13 - Register forms reject the accumulator as the general register operand.
module bwta_core (
	clock,
	rst,
	op_valid,
	op_ready,
	op_code,
	op_src,
	op_dst,
	op_reg,
	op_pair,
	op_imm,
	op_addr,
	op_fast,
	op_word,
	op_done,
	op_illegal,
	op_clocks,
	mem_rd,
	mem_wr,
	mem_addr,
	mem_wdata,
	mem_rdata,
	mem_ack,
	acc_out,
	x_out,
	flags_out
);
	input wire clock;
	input wire rst;
	input wire op_valid;
	output wire op_ready;
	input wire [3:0] op_code;
	input wire [1:0] op_src;
	input wire [1:0] op_dst;
	input wire [2:0] op_reg;
	input wire [1:0] op_pair;
	input wire [7:0] op_imm;
	input wire [15:0] op_addr;
	input wire op_fast;
	input wire op_word;
	output reg op_done;
	output reg op_illegal;
	output reg [7:0] op_clocks;
	output reg mem_rd;
	output reg mem_wr;
	output reg [15:0] mem_addr;
	output reg [7:0] mem_wdata;
	input wire [7:0] mem_rdata;
	input wire mem_ack;
	output wire [7:0] acc_out;
	output wire [7:0] x_out;
	output wire [2:0] flags_out;

	localparam ST_IDLE = 3'h0;
	localparam ST_RD = 3'h1;
	localparam ST_EXEC = 3'h2;
	localparam ST_WR = 3'h3;
	localparam ST_DONE = 3'h4;

	// Register file X,A,C,B,E,D,L,H indexed by the register code
	reg [7:0] rf_q [0:7];
	reg carry_flag_q;
	reg half_carry_flag_q;
	reg z_q;
	reg [2:0] st_q;
	reg [3:0] code_q;
	reg [1:0] src_q;
	reg [1:0] dst_q;
	reg [2:0] reg_q;
	reg [1:0] pair_q;
	reg [7:0] imm_q;
	reg [15:0] addr_q;
	reg word_q;
	reg fast_q;
	reg hi_q;
	reg [7:0] mem_q;
	reg [7:0] cnt_q;
	integer i;

	wire is_arith = code_q[2];
	wire is_sub = code_q[1];
	wire use_carry = code_q[0];
	wire [7:0] operand = (src_q == `BWTA_SRC_IMM) ? imm_q :
		(src_q == `BWTA_SRC_MEM) ? mem_q : rf_q[reg_q];
	wire [7:0] alu_a = (dst_q == `BWTA_DST_REG) ? rf_q[reg_q] :
		(dst_q == `BWTA_DST_MEM) ? mem_q : rf_q[`BWTA_R_A];
	wire [7:0] alu_b = (dst_q == `BWTA_DST_A) ? operand :
		(dst_q == `BWTA_DST_REG) ? rf_q[`BWTA_R_A] : imm_q;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_h;
	wire alu_z;

	bwta_alu8 u_alu (
		.a(alu_a),
		.b(alu_b),
		.cin(use_carry & carry_flag_q),
		.sub(is_sub),
		.res(alu_res),
		.cout(alu_c),
		.hout(alu_h),
		.zout(alu_z)
	);

	// Low register index of a pair
	function [2:0] pair_lo;
		input [1:0] p;
		begin
			pair_lo = {p, 1'b0};
		end
	endfunction

	// Decode of forms that are not provided
	function bad_form;
		input [3:0] c;
		input [1:0] s;
		input [1:0] d;
		input [2:0] r;
		input [1:0] p;
		begin
			bad_form = 1'b0;
			if (c == `BWTA_OP_MOVE_WORD_TO_AX || c == `BWTA_OP_MOVE_WORD_FROM_AX ||
				c == `BWTA_OP_EXCHANGE_WORD) begin
				if (s == `BWTA_SRC_REG && p == `BWTA_RP_AX)
					bad_form = 1'b1; // RULE11
			end else if (c > `BWTA_OP_SUBTRACT_WITH_BORROW) begin
				bad_form = 1'b1;
			end else if ((s == `BWTA_SRC_REG && (d == `BWTA_DST_A || !c[2])) ||
				(c[2] && d == `BWTA_DST_REG)) begin
				if (r == `BWTA_R_A)
					bad_form = 1'b1; // RULE13
			end
		end
	endfunction

	// Fast RAM data is taken from op_imm and writes to it are dropped, so it never sees a handshake
	wire needs_write = !fast_q && ((!is_arith && src_q == `BWTA_SRC_MEM &&
		code_q != `BWTA_OP_MOVE_WORD_TO_AX) || (is_arith && dst_q == `BWTA_DST_MEM));

	assign op_ready = (st_q == ST_IDLE);
	assign acc_out = rf_q[`BWTA_R_A];
	assign x_out = rf_q[`BWTA_R_X];
	assign flags_out = {z_q, half_carry_flag_q, carry_flag_q};

	always @(posedge clock) begin
		if (rst) begin
			for (i = 0; i < 8; i = i + 1)
				rf_q[i] <= `BWTA_REG_RESET;
			carry_flag_q <= `BWTA_FLAG_RESET;
			half_carry_flag_q <= `BWTA_FLAG_RESET;
			z_q <= `BWTA_FLAG_RESET;
			st_q <= ST_IDLE;
			code_q <= 4'h0;
			src_q <= 2'h0;
			dst_q <= 2'h0;
			reg_q <= 3'h0;
			pair_q <= 2'h0;
			imm_q <= 8'h00;
			addr_q <= 16'h0000;
			word_q <= 1'b0;
			fast_q <= 1'b0;
			hi_q <= 1'b0;
			mem_q <= 8'h00;
			cnt_q <= 8'h00;
			op_done <= 1'b0;
			op_illegal <= 1'b0;
			op_clocks <= 8'h00;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
		end else begin
			op_done <= 1'b0;
			op_illegal <= 1'b0;
			// Each state edge is one core clock period
			if (st_q != ST_IDLE)
				cnt_q <= cnt_q + 8'h01; // RULE2
			case (st_q)
			ST_IDLE: begin
				cnt_q <= 8'h01;
				hi_q <= 1'b0;
				if (op_valid) begin
					if (bad_form(op_code, op_src, op_dst, op_reg, op_pair)) begin
						op_illegal <= 1'b1; // RULE13
					end else begin
						code_q <= op_code;
						src_q <= op_src;
						dst_q <= op_dst;
						reg_q <= op_reg;
						pair_q <= op_pair;
						imm_q <= op_imm;
						addr_q <= op_addr;
						word_q <= op_word;
						fast_q <= op_fast;
						// Fast RAM and register forms need no memory stretch
						if (op_fast || (op_src != `BWTA_SRC_MEM &&
							!(op_code[2] && op_dst == `BWTA_DST_MEM))) begin
							st_q <= ST_EXEC; // RULE1
							mem_q <= op_imm;
						end else if (op_code != `BWTA_OP_MOVE_WORD_FROM_AX) begin
							st_q <= ST_RD;
							mem_rd <= 1'b1;
							mem_addr <= op_addr;
						end else begin
							st_q <= ST_EXEC;
						end
					end
				end
			end
			ST_RD: begin
				// Read stays up until the memory ends its read wait states
				if (mem_ack) begin
					mem_rd <= 1'b0; // RULE4
					mem_q <= mem_rdata;
					if (word_q && !hi_q && code_q == `BWTA_OP_MOVE_WORD_TO_AX) begin
						rf_q[`BWTA_R_X] <= mem_rdata;
						hi_q <= 1'b1;
						mem_rd <= 1'b1;
						mem_addr <= addr_q + 16'h0001;
					end else begin
						st_q <= ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				st_q <= ST_DONE;
				case (code_q)
				`BWTA_OP_XCHB: begin
					// Flags are left alone for exchange
					rf_q[`BWTA_R_A] <= operand; // RULE6
					if (src_q == `BWTA_SRC_REG)
						rf_q[reg_q] <= rf_q[`BWTA_R_A];
					mem_wdata <= rf_q[`BWTA_R_A];
				end
				`BWTA_OP_MOVE_WORD_TO_AX: begin
					if (src_q == `BWTA_SRC_REG) begin
						rf_q[`BWTA_R_X] <= rf_q[pair_lo(pair_q)]; // RULE11
						rf_q[`BWTA_R_A] <= rf_q[pair_lo(pair_q) + 3'h1];
					end else begin
						rf_q[`BWTA_R_A] <= mem_q;
					end
				end
				`BWTA_OP_MOVE_WORD_FROM_AX: begin
					if (src_q == `BWTA_SRC_REG) begin
						rf_q[pair_lo(pair_q)] <= rf_q[`BWTA_R_X]; // RULE11
						rf_q[pair_lo(pair_q) + 3'h1] <= rf_q[`BWTA_R_A];
					end
					mem_wdata <= rf_q[`BWTA_R_X];
				end
				`BWTA_OP_EXCHANGE_WORD: begin
					rf_q[`BWTA_R_X] <= rf_q[pair_lo(pair_q)]; // RULE11
					rf_q[`BWTA_R_A] <= rf_q[pair_lo(pair_q) + 3'h1];
					rf_q[pair_lo(pair_q)] <= rf_q[`BWTA_R_X];
					rf_q[pair_lo(pair_q) + 3'h1] <= rf_q[`BWTA_R_A];
				end
				default: begin
					// Add, add with carry, subtract, subtract with borrow
					carry_flag_q <= alu_c; // RULE7 RULE8 RULE9 RULE10
					half_carry_flag_q <= alu_h; // RULE12
					z_q <= alu_z; // RULE12
					if (dst_q == `BWTA_DST_A)
						rf_q[`BWTA_R_A] <= alu_res;
					else if (dst_q == `BWTA_DST_REG)
						rf_q[reg_q] <= alu_res;
					mem_wdata <= alu_res;
				end
				endcase
				if (needs_write) begin
					st_q <= ST_WR;
					mem_wr <= 1'b1;
					mem_addr <= addr_q;
					hi_q <= 1'b0;
				end
			end
			ST_WR: begin
				// Write stays up until the memory ends its write wait states
				if (mem_ack) begin
					mem_wr <= 1'b0; // RULE5
					if (word_q && !hi_q && code_q == `BWTA_OP_MOVE_WORD_FROM_AX) begin
						hi_q <= 1'b1;
						mem_wr <= 1'b1;
						mem_addr <= addr_q + 16'h0001;
						mem_wdata <= rf_q[`BWTA_R_A]; // RULE5
					end else begin
						st_q <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				// Count is as measured with fetch from internal ROM
				op_done <= 1'b1; // RULE3
				op_clocks <= cnt_q;
				st_q <= ST_IDLE;
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ==== dv/bwta_mem_model.sv ====
// Far-side memory with a wait count; read data toggles while no access is pending.
// Assumes one byte access at a time from the datapath.
`timescale 1ns/1ps
module bwta_mem_model (
	input wire clock,
	input wire mem_rd,
	input wire mem_wr,
	input wire [15:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire [3:0] waits,
	output reg [7:0] mem_rdata,
	output reg mem_ack
);
	reg [7:0] mem [0:255];
	reg [3:0] cnt_q;
	integer i;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
		cnt_q = 4'h0;
		for (i = 0; i < 256; i = i + 1)
			mem[i] = i[7:0] ^ 8'h5A;
	end
	always @(posedge clock) begin
		mem_ack <= 1'b0;
		if ((mem_rd || mem_wr) && !mem_ack) begin
			if (cnt_q == waits) begin
				mem_ack <= 1'b1;
				cnt_q <= 4'h0;
				mem_rdata <= mem[mem_addr[7:0]];
				if (mem_wr)
					mem[mem_addr[7:0]] <= mem_wdata;
			end else
				cnt_q <= cnt_q + 4'h1;
		end else if (!mem_ack)
			mem_rdata <= ~mem_rdata;
	end
endmodule

// ==== dv/bwta_core_chk.sv ====
// Port timing checks for the datapath.
// Assumes binding onto every bwta_core.
`timescale 1ns/1ps
module bwta_core_chk (
	input clock,
	input rst,
	input op_valid,
	input op_ready,
	input [3:0] op_code,
	input [1:0] op_src,
	input [1:0] op_dst,
	input [2:0] op_reg,
	input [1:0] op_pair,
	input op_fast,
	input op_done,
	input op_illegal,
	input mem_rd,
	input mem_wr,
	input mem_ack,
	input [2:0] flags_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	wire tk = op_valid && op_ready;
	wire ar = op_code[3:2] == 2'h1;
	wire wd = op_code == 4'h1 || op_code == 4'h2 || op_code == 4'h3;
	property p_rd_hold; mem_rd && !mem_ack |=> mem_rd; endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rd hold");
	property p_wr_hold; mem_wr && !mem_ack |=> mem_wr; endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("wr hold");
	property p_done; op_done |-> op_ready ##1 !op_done; endproperty
	a_done: assert property (p_done) else $error("done pulse");
	property p_imm; tk && ar && op_src == 2'h1 && op_dst == 2'h0 && !op_fast
		|-> ##[1:3] op_done; endproperty
	a_imm: assert property (p_imm) else $error("imm latency");
	property p_fast; tk && op_fast |=> (!mem_rd && !mem_wr) [*3]; endproperty
	a_fast: assert property (p_fast) else $error("fast mem");
	property p_acc; tk && op_src == 2'h0 && op_reg == 3'h1 &&
		(op_code == 4'h0 || (ar && op_dst != 2'h2))
		|-> ##[1:2] op_illegal; endproperty
	a_acc: assert property (p_acc) else $error("acc operand");
	property p_pair; tk && op_src == 2'h0 && wd && op_pair == 2'h0 |-> ##[1:2] op_illegal;
	endproperty
	a_pair: assert property (p_pair) else $error("pair");
	property p_flags; tk && op_code[3:2] == 2'h0 |=> $stable(flags_out) [*3]; endproperty
	a_flags: assert property (p_flags) else $error("flags moved");
	c_ill: cover property (op_illegal);
	c_rd: cover property (mem_rd && mem_ack);
	c_wr: cover property (mem_wr && mem_ack);
endmodule
bind bwta_core bwta_core_chk u_chk (.*);

// ==== dv/test_byte_word_transfer_arith.sv ====
// Self-checking bench for the transfer and arithmetic datapath.
// Assumes the memory model on the far side and the bound checker.
`timescale 1ns/1ps
module test_byte_word_transfer_arith;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg op_valid = 1'b0;
	reg [3:0] op_code = 4'h0;
	reg [1:0] op_src = 2'h0;
	reg [1:0] op_dst = 2'h0;
	reg [2:0] op_reg = 3'h0;
	reg [1:0] op_pair = 2'h0;
	reg [7:0] op_imm = 8'h00;
	reg [15:0] op_addr = 16'h0000;
	reg op_fast = 1'b0;
	reg op_word = 1'b0;
	reg [3:0] waits = 4'h0;
	wire op_ready, op_done, op_illegal, mem_rd, mem_wr, mem_ack;
	wire [7:0] op_clocks, mem_wdata, mem_rdata, acc_out, x_out;
	wire [15:0] mem_addr;
	wire [2:0] flags_out;
	integer fail_count = 0;
	integer n_tests = 0;
	integer ma = 0, mx = 0, mbc = 0, k, t, b;
	reg [2:0] mf = 3'h0;
	reg [7:0] mm [0:255];
	reg ill;
	bwta_core u_dut (
		.clock(clock),
		.rst(rst),
		.op_valid(op_valid),
		.op_ready(op_ready),
		.op_code(op_code),
		.op_src(op_src),
		.op_dst(op_dst),
		.op_reg(op_reg),
		.op_pair(op_pair),
		.op_imm(op_imm),
		.op_addr(op_addr),
		.op_fast(op_fast),
		.op_word(op_word),
		.op_done(op_done),
		.op_illegal(op_illegal),
		.op_clocks(op_clocks),
		.mem_rd(mem_rd),
		.mem_wr(mem_wr),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.mem_ack(mem_ack),
		.acc_out(acc_out),
		.x_out(x_out),
		.flags_out(flags_out)
	);
	bwta_mem_model u_mem (
		.clock(clock),
		.mem_rd(mem_rd),
		.mem_wr(mem_wr),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.waits(waits),
		.mem_rdata(mem_rdata),
		.mem_ack(mem_ack)
	);
	initial forever #2.5 clock = ~clock;
	task tally_and_finish;
		$display("Tests %0d failures %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk_byte(input [7:0] e, input [7:0] a);
		n_tests = n_tests + 1;
		if (a !== e) begin
			fail_count = fail_count + 1;
			$display("Error t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task chk_flag(input [2:0] e, input [2:0] a);
		chk_byte({5'h00, e}, {5'h00, a});
	endtask
	task run(input [3:0] c, input [1:0] s, input [2:0] r, input [1:0] p, input [7:0] i);
		@(posedge clock);
		#1;
		op_code = c;
		op_src = s;
		op_reg = r;
		op_pair = p;
		op_imm = i;
		op_valid = 1'b1;
		@(posedge clock);
		#1;
		op_valid = 1'b0;
		ill = op_illegal;
		for (k = 0; op_done !== 1'b1 && ill !== 1'b1 && k < 40; k = k + 1) begin
			@(posedge clock);
			#1;
			ill = op_illegal;
		end
		if (op_done !== 1'b1 && ill !== 1'b1) begin
			fail_count = fail_count + 1;
			$display("Error t=%0t timeout", $time);
			tally_and_finish;
		end
	endtask
	task arith(input [3:0] c, input [7:0] v);
		integer ci, r, h;
		ci = c[0] ? mf[0] : 0;
		if (c[1]) begin
			r = ma - v - ci;
			h = (ma & 15) - (v & 15) - ci;
		end else begin
			r = ma + v + ci;
			h = (ma & 15) + (v & 15) + ci;
		end
		mf = {r[7:0] == 8'h00, h[4], r[8]};
		ma = r & 255;
	endtask
	initial begin
		t = $urandom(20);
		for (k = 0; k < 256; k = k + 1)
			mm[k] = k[7:0] ^ 8'h5A;
		repeat (3) @(posedge clock);
		#1;
		rst = 1'b0;
		chk_byte(8'h00, acc_out);
		chk_flag(3'h0, flags_out);
		for (t = 0; t < 32; t = t + 1) begin
			b = (t % 8 == 6) ? ma : $urandom % 256;
			arith(4'h4 + t % 4, b);
			run(4'h4 + t % 4, 2'h1, 3'h0, 2'h0, b);
			chk_byte(ma, acc_out);
			chk_flag(mf, flags_out);
		end
		$display("arith test done");
		for (t = 0; t < 3; t = t + 1) begin
			run(t == 0 ? 4'h4 : t == 1 ? 4'h0 : 4'h3, 2'h0, 3'h1, 2'h0, 8'h00);
			chk_flag(3'h1, {2'h0, ill});
			chk_byte(ma, acc_out);
		end
		$display("illegal test done");
		run(4'h0, 2'h0, 3'h0, 2'h0, 8'h00);
		b = ma;
		ma = mx;
		mx = b;
		chk_byte(ma, acc_out);
		chk_byte(mx, x_out);
		run(4'h3, 2'h0, 3'h0, 2'h1, 8'h00);
		b = ma * 256 + mx;
		ma = mbc / 256;
		mx = mbc % 256;
		mbc = b;
		chk_byte(ma, acc_out);
		chk_byte(mx, x_out);
		run(4'h1, 2'h0, 3'h0, 2'h1, 8'h00);
		chk_byte(mbc / 256, acc_out);
		chk_byte(mbc % 256, x_out);
		chk_flag(mf, flags_out);
		ma = mbc / 256;
		mx = mbc % 256;
		$display("exchange test done");
		for (t = 0; t < 4; t = t + 1) begin
			waits = t;
			op_addr = $urandom % 256;
			arith(4'h4, mm[op_addr[7:0]]);
			run(4'h4, 2'h2, 3'h0, 2'h0, 8'h00);
			chk_byte(4 + t, op_clocks);
			chk_byte(ma, acc_out);
			b = mm[op_addr[7:0]];
			mm[op_addr[7:0]] = ma;
			ma = b;
			run(4'h0, 2'h2, 3'h0, 2'h0, 8'h00);
			chk_byte(ma, acc_out);
			b = mm[op_addr[7:0]];
			mm[op_addr[7:0]] = ma;
			ma = b;
			run(4'h0, 2'h2, 3'h0, 2'h0, 8'h00);
			chk_byte(ma, acc_out);
		end
		$display("memory test done");
		op_word = 1'b1;
		op_addr = 16'h0040;
		run(4'h2, 2'h2, 3'h0, 2'h0, 8'h00);
		mm[64] = mx;
		mm[65] = ma;
		for (t = 0; t < 2; t = t + 1) begin
			op_addr = t ? 16'h0040 : 16'h0020;
			run(4'h1, 2'h2, 3'h0, 2'h0, 8'h00);
			mx = mm[op_addr[7:0]];
			ma = mm[op_addr[7:0] + 1];
			chk_byte(mx, x_out);
			chk_byte(ma, acc_out);
		end
		op_word = 1'b0;
		$display("word memory test done");
		op_dst = 2'h2;
		op_addr = 16'h0033;
		b = ma;
		ma = mm[51];
		arith(4'h6, 8'h21);
		run(4'h6, 2'h1, 3'h0, 2'h0, 8'h21);
		chk_flag(mf, flags_out);
		mm[51] = ma;
		ma = b;
		chk_byte(ma, acc_out);
		op_dst = 2'h1;
		b = ma;
		ma = mx;
		arith(4'h5, b);
		run(4'h5, 2'h0, 3'h0, 2'h0, 8'h00);
		mx = ma;
		ma = b;
		chk_byte(mx, x_out);
		chk_flag(mf, flags_out);
		op_dst = 2'h0;
		run(4'h0, 2'h2, 3'h0, 2'h0, 8'h00);
		b = mm[51];
		mm[51] = ma;
		ma = b;
		chk_byte(ma, acc_out);
		$display("operand form test done");
		op_fast = 1'b1;
		b = $urandom % 256;
		arith(4'h4, b);
		run(4'h4, 2'h2, 3'h0, 2'h0, b);
		chk_byte(ma, acc_out);
		chk_byte(8'h02, op_clocks);
		$display("fast test done");
		tally_and_finish;
	end
endmodule
